/* File: verilog/flash_seq_pkg.sv */
// Constants and carrier types of the in-application flash sequencer
`default_nettype none
package flash_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special-function register addresses
  localparam logic [7:0] SFR_CHIP_CONTROL  = 8'h9F;
  localparam logic [7:0] SFR_OP_TRIGGER    = 8'hA4;
  localparam logic [7:0] SFR_REGION_UEN    = 8'hA5;
  localparam logic [7:0] SFR_ADDR_LOW      = 8'hA6;
  localparam logic [7:0] SFR_ADDR_HIGH     = 8'hA7;
  localparam logic [7:0] SFR_DATA          = 8'hAE;
  localparam logic [7:0] SFR_COMMAND       = 8'hAF;
  localparam logic [7:0] SFR_TIMED_ACCESS  = 8'hC7;

  // Reset values
  localparam logic [7:0] CHIP_CONTROL_RST  = 8'h00;
  localparam logic [2:0] REGION_UEN_RST    = 3'h0;
  localparam logic [15:0] ADDR_RST         = 16'h0000;
  localparam logic [7:0] DATA_RST          = 8'h00;
  localparam logic [7:0] COMMAND_RST       = 8'h30;

  // Timed-access unlock pair
  localparam logic [7:0] TA_KEY_FIRST      = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND     = 8'h55;

  // Field positions
  localparam int CC_EN_BIT      = 0;
  localparam int CC_FAULT_BIT   = 6;
  localparam int TRIG_GO_BIT    = 0;
  localparam int UEN_MAIN_BIT   = 0;
  localparam int UEN_BOOT_BIT   = 1;
  localparam int UEN_CFG_BIT    = 2;
  localparam int CMD_BLK_LSB    = 6;
  localparam int PAGE_BITS      = 8;

  // Block select codes
  localparam logic [1:0] BLK_MAIN = 2'h0;
  localparam logic [1:0] BLK_BOOT = 2'h1;
  localparam logic [1:0] BLK_CFG  = 2'h3;

  // Operation codes: {output_enable_bit, control_enable_bit, function_code}
  localparam logic [5:0] OP_READ  = 6'h00;
  localparam logic [5:0] OP_PROG  = 6'h21;
  localparam logic [5:0] OP_ERASE = 6'h22;
  localparam logic [5:0] OP_MAKER = 6'h0B;
  localparam logic [5:0] OP_PART  = 6'h0C;
  localparam logic [5:0] OP_UID   = 6'h04;

  // Address limits
  localparam logic [15:0] CFG_ADDR_MAX  = 16'h0004;
  localparam logic [15:0] CFG_ADDR_GAP  = 16'h0003;
  localparam logic [15:0] PART_ADDR_MAX = 16'h0001;
  localparam logic [15:0] UID_ADDR_MAX  = 16'h000B;

  // Timing
  localparam int CLK_MHZ       = 200;
  localparam int PROG_TIME_NS  = 50000;
  localparam int ERASE_TIME_US = 28000;
  localparam int PROG_CYCLES   = PROG_TIME_NS * CLK_MHZ / 1000;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 23;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_PROG  = 3'b010,
    ST_ERASE = 3'b011
  } op_state_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic        rd;
    logic        prog;
    logic        erase;
    logic [1:0]  region;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } flash_req_t;

  typedef struct packed {
    op_state_t        st;
    logic [1:0]       ta_stage;
    logic             en;
    logic             fault;
    logic [2:0]       uen;
    logic [15:0]      addr;
    logic [7:0]       data;
    logic [7:0]       cmd;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       bo_sync;
    logic             bo_low;
    logic [7:0]       rdata;
  } ctl_state_t;

endpackage : flash_seq_pkg
`default_nettype wire

/* File: verilog/in_app_flash_program_ctrl.sv */
// In-application flash sequencer: SFR file, command decode, fault checks, timing
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Fault when the target address exceeds the selected region size.
// - Fault when the command encoding is not a defined code.
// - Fault and no flash change when erasing/programming a region not enabled.
// - Fault and block modify under brown-out with inhibit, detect on, reset off.
// - Fault flag stays set until software clears it.
// - Bit 0 of chip control enables the sequencer and the RC oscillator.
// - Update enables: bit 2 config, bit 1 boot, bit 0 main area.
// - Protected writes accepted only right after unlock bytes AA then 55.
// - Block field: 00 main, 01 boot, 11 configuration bytes.
// - Commands: 0/0/0000 read, 1/0/0001 program, 1/0/0010 page erase.
// - Code 1011 returns maker code; 1100 returns part code low/high by address.
// - Code 0100 returns unique code byte for addresses 0 to B.
// - Config bytes at 0,1,2,4; config erase clears them all together.
// - Erase works on 256-byte pages chosen by the address high byte.
// - Trigger stalls the CPU until the operation finishes.
// - Trigger bit self-clears and always reads zero.
// - Program uses loaded data; read result lands in data register.
// - Target address is high register bits 15:8, low register bits 7:0.
// - Clearing the enable blocks triggers and stops the RC oscillator.
// - Code lock does not restrict any operation.
// - Erase and program are timed internally: 28 ms and 50 us.
module in_app_flash_program_ctrl #(
  parameter int unsigned PROG_CYC   = flash_seq_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYC  = flash_seq_pkg::ERASE_CYCLES,
  parameter logic [15:0] MAIN_SIZE  = 16'h4000,
  parameter logic [15:0] BOOT_SIZE  = 16'h1000,
  parameter logic [7:0]  MAKER_CODE = 8'h5A,   // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h1234 // Arbitrary value
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  // Special-function register port
  input  wire flash_seq_pkg::sfr_req_t   sfr_req_i,
  output logic [7:0]                     sfr_rdata_o,
  // Brown-out and configuration levels
  input  wire logic                      brownout_low_i,
  input  wire logic                      brownout_inhibit_i,
  input  wire logic                      brownout_detect_enable_i,
  input  wire logic                      brownout_reset_enable_i,
  input  wire logic [95:0]               unique_code_i,
  // CPU and clock control
  output logic                           cpu_hold_o,
  output logic                           internal_rc_osc_en_o,
  // Flash array
  output flash_seq_pkg::flash_req_t      flash_req_o,
  input  wire logic [7:0]                flash_rdata_i
);

  flash_seq_pkg::ctl_state_t cur_r;
  flash_seq_pkg::ctl_state_t cur_nxt;

  logic        prot_ok;
  logic        go;
  logic [5:0]  op;
  logic [1:0]  blk;
  logic        bad_cmd;
  logic        oversize;
  logic        is_mod;
  logic        uen_ok;
  logic        bo_block;
  logic        fault_evt;
  logic [15:0] region_lim;

  //////////////////////////////////////////////////////////////////////////////
  // Decode and checks
  assign prot_ok = sfr_req_i.wr && (cur_r.ta_stage == 2'd2);
  assign go = prot_ok && (sfr_req_i.addr == flash_seq_pkg::SFR_OP_TRIGGER)
              && sfr_req_i.wdata[flash_seq_pkg::TRIG_GO_BIT]
              && cur_r.en && (cur_r.st == flash_seq_pkg::ST_IDLE);
  assign op  = cur_r.cmd[5:0];
  assign blk = cur_r.cmd[7:flash_seq_pkg::CMD_BLK_LSB];
  assign is_mod = (op == flash_seq_pkg::OP_PROG) || (op == flash_seq_pkg::OP_ERASE);
  // Lock state is deliberately not an input: it never gates anything

  always_comb begin
    bad_cmd = 1'b0;
    case (op)
      flash_seq_pkg::OP_READ,
      flash_seq_pkg::OP_PROG,
      flash_seq_pkg::OP_ERASE: bad_cmd = (blk == 2'h2);
      flash_seq_pkg::OP_MAKER,
      flash_seq_pkg::OP_PART,
      flash_seq_pkg::OP_UID:   bad_cmd = 1'b0;
      default:                 bad_cmd = 1'b1;
    endcase
  end

  always_comb begin
    region_lim = MAIN_SIZE;
    uen_ok     = cur_r.uen[flash_seq_pkg::UEN_MAIN_BIT];
    case (blk)
      flash_seq_pkg::BLK_BOOT: begin
        region_lim = BOOT_SIZE;
        uen_ok     = cur_r.uen[flash_seq_pkg::UEN_BOOT_BIT];
      end
      flash_seq_pkg::BLK_CFG: begin
        region_lim = flash_seq_pkg::CFG_ADDR_MAX + 16'h0001;
        uen_ok     = cur_r.uen[flash_seq_pkg::UEN_CFG_BIT];
      end
      default: begin
        region_lim = MAIN_SIZE;
        uen_ok     = cur_r.uen[flash_seq_pkg::UEN_MAIN_BIT];
      end
    endcase
  end

  always_comb begin
    oversize = 1'b0;
    case (op)
      flash_seq_pkg::OP_PART: oversize = cur_r.addr > flash_seq_pkg::PART_ADDR_MAX;
      flash_seq_pkg::OP_UID:  oversize = cur_r.addr > flash_seq_pkg::UID_ADDR_MAX;
      flash_seq_pkg::OP_READ,
      flash_seq_pkg::OP_PROG,
      flash_seq_pkg::OP_ERASE: begin
        if (blk == flash_seq_pkg::BLK_CFG) begin
          // Config erase clears every byte, so its address is not checked
          oversize = (op != flash_seq_pkg::OP_ERASE)
                     && ((cur_r.addr >= region_lim)
                         || (cur_r.addr == flash_seq_pkg::CFG_ADDR_GAP));
        end else begin
          oversize = cur_r.addr >= region_lim;
        end
      end
      default: oversize = 1'b0;
    endcase
  end

  assign bo_block = cur_r.bo_low && brownout_inhibit_i
                    && brownout_detect_enable_i && !brownout_reset_enable_i;
  assign fault_evt = go && (bad_cmd || oversize || (is_mod && !uen_ok)
                            || (is_mod && bo_block));

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    cur_nxt = cur_r;
    // Brown-out level: three flops, change taken once the last two agree
    cur_nxt.bo_sync = {cur_r.bo_sync[1:0], brownout_low_i};
    if (cur_r.bo_sync[1] == cur_r.bo_sync[2]) begin
      cur_nxt.bo_low = cur_r.bo_sync[2];
    end
    // Unlock window closes on any other write
    if (sfr_req_i.wr) begin
      cur_nxt.ta_stage = 2'd0;
      if (sfr_req_i.addr == flash_seq_pkg::SFR_TIMED_ACCESS) begin
        if (sfr_req_i.wdata == flash_seq_pkg::TA_KEY_FIRST) begin
          cur_nxt.ta_stage = 2'd1;
        end else if ((sfr_req_i.wdata == flash_seq_pkg::TA_KEY_SECOND)
                     && (cur_r.ta_stage == 2'd1)) begin
          cur_nxt.ta_stage = 2'd2;
        end
      end
      case (sfr_req_i.addr)
        flash_seq_pkg::SFR_CHIP_CONTROL: begin
          if (prot_ok) begin
            cur_nxt.en    = sfr_req_i.wdata[flash_seq_pkg::CC_EN_BIT];
            cur_nxt.fault = cur_r.fault & sfr_req_i.wdata[flash_seq_pkg::CC_FAULT_BIT];
          end
        end
        flash_seq_pkg::SFR_REGION_UEN: begin
          if (prot_ok) begin
            cur_nxt.uen = sfr_req_i.wdata[2:0];
          end
        end
        flash_seq_pkg::SFR_ADDR_LOW:  cur_nxt.addr[7:0]  = sfr_req_i.wdata;
        flash_seq_pkg::SFR_ADDR_HIGH: cur_nxt.addr[15:8] = sfr_req_i.wdata;
        flash_seq_pkg::SFR_DATA:      cur_nxt.data       = sfr_req_i.wdata;
        flash_seq_pkg::SFR_COMMAND:   cur_nxt.cmd        = sfr_req_i.wdata;
        default: ;
      endcase
    end
    // Hardware set beats a software clear in the same cycle
    if (fault_evt) begin
      cur_nxt.fault = 1'b1;
    end
    case (cur_r.st)
      flash_seq_pkg::ST_IDLE: begin
        if (go && !fault_evt) begin
          case (op)
            flash_seq_pkg::OP_READ: cur_nxt.st = flash_seq_pkg::ST_READ;
            flash_seq_pkg::OP_PROG: begin
              cur_nxt.st  = flash_seq_pkg::ST_PROG;
              cur_nxt.cnt = flash_seq_pkg::CNT_W'(PROG_CYC - 1);
            end
            flash_seq_pkg::OP_ERASE: begin
              cur_nxt.st  = flash_seq_pkg::ST_ERASE;
              cur_nxt.cnt = flash_seq_pkg::CNT_W'(ERASE_CYC - 1);
            end
            flash_seq_pkg::OP_MAKER: cur_nxt.data = MAKER_CODE;
            flash_seq_pkg::OP_PART:
              cur_nxt.data = cur_r.addr[0] ? PART_CODE[15:8] : PART_CODE[7:0];
            flash_seq_pkg::OP_UID:
              cur_nxt.data = unique_code_i[{cur_r.addr[3:0], 3'b000} +: 8];
            default: ;
          endcase
        end
      end
      flash_seq_pkg::ST_READ: begin
        cur_nxt.data = flash_rdata_i;
        cur_nxt.st   = flash_seq_pkg::ST_IDLE;
      end
      flash_seq_pkg::ST_PROG,
      flash_seq_pkg::ST_ERASE: begin
        if (cur_r.cnt == '0) begin
          cur_nxt.st = flash_seq_pkg::ST_IDLE;
        end else begin
          cur_nxt.cnt = cur_r.cnt - 1'b1;
        end
      end
      default: cur_nxt.st = flash_seq_pkg::ST_IDLE;
    endcase
    // Registered read-back of the addressed register
    case (sfr_req_i.addr)
      flash_seq_pkg::SFR_CHIP_CONTROL: begin
        cur_nxt.rdata = 8'h00;
        cur_nxt.rdata[flash_seq_pkg::CC_EN_BIT]    = cur_r.en;
        cur_nxt.rdata[flash_seq_pkg::CC_FAULT_BIT] = cur_r.fault;
      end
      flash_seq_pkg::SFR_REGION_UEN: cur_nxt.rdata = {5'h00, cur_r.uen};
      flash_seq_pkg::SFR_ADDR_LOW:   cur_nxt.rdata = cur_r.addr[7:0];
      flash_seq_pkg::SFR_ADDR_HIGH:  cur_nxt.rdata = cur_r.addr[15:8];
      flash_seq_pkg::SFR_DATA:       cur_nxt.rdata = cur_r.data;
      flash_seq_pkg::SFR_COMMAND:    cur_nxt.rdata = cur_r.cmd;
      default:                       cur_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_r          <= '0;
      cur_r.st       <= flash_seq_pkg::ST_IDLE;
      cur_r.en       <= flash_seq_pkg::CHIP_CONTROL_RST[flash_seq_pkg::CC_EN_BIT];
      cur_r.fault    <= flash_seq_pkg::CHIP_CONTROL_RST[flash_seq_pkg::CC_FAULT_BIT];
      cur_r.uen      <= flash_seq_pkg::REGION_UEN_RST;
      cur_r.addr     <= flash_seq_pkg::ADDR_RST;
      cur_r.data     <= flash_seq_pkg::DATA_RST;
      cur_r.cmd      <= flash_seq_pkg::COMMAND_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sfr_rdata_o          = cur_r.rdata;
  assign cpu_hold_o           = cur_r.st != flash_seq_pkg::ST_IDLE;
  // Oscillator stays on through an operation even if enable drops
  assign internal_rc_osc_en_o = cur_r.en || cpu_hold_o;
  assign flash_req_o.rd       = cur_r.st == flash_seq_pkg::ST_READ;
  assign flash_req_o.prog     = cur_r.st == flash_seq_pkg::ST_PROG;
  assign flash_req_o.erase    = cur_r.st == flash_seq_pkg::ST_ERASE;
  assign flash_req_o.region   = blk;
  assign flash_req_o.addr     = flash_req_o.erase
                                ? {cur_r.addr[15:flash_seq_pkg::PAGE_BITS],
                                   {flash_seq_pkg::PAGE_BITS{1'b0}}}
                                : cur_r.addr;
  assign flash_req_o.wdata    = cur_r.data;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_fault_sticky;
    $fell(cur_r.fault) |-> $past(prot_ok)
      && ($past(sfr_req_i.addr) == flash_seq_pkg::SFR_CHIP_CONTROL);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault flag cleared without software write");

  property p_trig_reads_zero;
    $past(sfr_req_i.addr) == flash_seq_pkg::SFR_OP_TRIGGER |-> sfr_rdata_o == 8'h00;
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero)
    else $error("trigger register read back nonzero");

  property p_osc_on;
    cur_r.en |-> internal_rc_osc_en_o;
  endproperty
  a_osc_on: assert property (p_osc_on)
    else $error("oscillator off while enabled");

  property p_hold_after_go;
    go && !fault_evt && (op == flash_seq_pkg::OP_PROG) |=> cpu_hold_o [*8];
  endproperty
  a_hold_after_go: assert property (p_hold_after_go)
    else $error("cpu not held during program");

  property p_prog_timed;
    go && !fault_evt && (op == flash_seq_pkg::OP_PROG)
      |=> flash_req_o.prog && (cur_r.cnt == flash_seq_pkg::CNT_W'(PROG_CYC - 1));
  endproperty
  a_prog_timed: assert property (p_prog_timed)
    else $error("program count not loaded");

  property p_uen_block;
    go && (op == flash_seq_pkg::OP_ERASE) && !uen_ok
      |=> cur_r.fault && !flash_req_o.erase ##1 !flash_req_o.erase;
  endproperty
  a_uen_block: assert property (p_uen_block)
    else $error("erase of disabled region not refused");

  property p_disabled_ignore;
    sfr_req_i.wr && (sfr_req_i.addr == flash_seq_pkg::SFR_OP_TRIGGER) && !cur_r.en
      && (cur_r.st == flash_seq_pkg::ST_IDLE) |=> !cpu_hold_o && $stable(cur_r.data);
  endproperty
  a_disabled_ignore: assert property (p_disabled_ignore)
    else $error("trigger acted while disabled");

  property p_page_aligned;
    flash_req_o.erase |-> flash_req_o.addr[7:0] == 8'h00;
  endproperty
  a_page_aligned: assert property (p_page_aligned)
    else $error("erase address not page aligned");

  property p_bad_cmd_fault;
    go && bad_cmd |=> cur_r.fault && !cpu_hold_o;
  endproperty
  a_bad_cmd_fault: assert property (p_bad_cmd_fault)
    else $error("invalid command did not fault");

  property p_no_unlock;
    sfr_req_i.wr && (sfr_req_i.addr == flash_seq_pkg::SFR_REGION_UEN)
      && (cur_r.ta_stage != 2'd2) |=> $stable(cur_r.uen);
  endproperty
  a_no_unlock: assert property (p_no_unlock)
    else $error("protected register written while locked");

endmodule : in_app_flash_program_ctrl
`default_nettype wire

/* File: test/flash_array_model.sv */
// Behavioural flash array that answers the sequencer's read, program and erase strobes
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // Clock
  input  wire logic                      clk_i,
  // Sequencer side
  input  wire flash_seq_pkg::flash_req_t req_i,
  output logic [7:0]                     rdata_o
);
  logic [7:0]  mem [logic [17:0]];
  logic [7:0]  last_r = 8'h00;
  logic        prog_d = 1'b0;
  logic        erase_d = 1'b0;
  logic [17:0] key;

  assign key = {req_i.region, req_i.addr};

  ////////////////////////////////////////////////////////////////////////////
  // Outside a read the bus keeps no value, so show the inverse of the last byte
  always @* begin
    if (req_i.rd) begin
      rdata_o = mem.exists(key) ? mem[key] : 8'hFF;
    end else begin
      rdata_o = ~last_r;
    end
  end

  // Programming can only clear bits; an erased byte is absent from the map
  always @(posedge clk_i) begin
    prog_d <= req_i.prog;
    erase_d <= req_i.erase;
    if (req_i.rd) last_r <= rdata_o;
    if (req_i.prog && !prog_d) mem[key] = (mem.exists(key) ? mem[key] : 8'hFF) & req_i.wdata;
    if (req_i.erase && !erase_d) begin
      for (int i = 0; i < 256; i++) mem.delete({req_i.region, req_i.addr[15:8], i[7:0]});
    end
  end
endmodule : flash_array_model
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench of the in-application flash sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
  localparam int          PC    = 8;
  localparam int          EC    = 16;
  localparam logic [7:0]  MAKER = 8'h3C;    // Arbitrary value
  localparam logic [15:0] PART  = 16'hA5C3; // Arbitrary value
  logic                       sys_clk = 1'b0;
  logic                       rst_b;
  flash_seq_pkg::sfr_req_t    sfr_req;
  logic [7:0]                 sfr_rdata;
  logic                       bo_low, bo_inh, bo_det, bo_rst;
  logic [95:0]                uid = 96'h0123_4567_89AB_CDEF_FEDC_BA98;
  logic                       cpu_hold, osc_en;
  flash_seq_pkg::flash_req_t  freq, seen;
  logic [7:0]                 frdata;
  int                         err_count = 0, cmp_count = 0, cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  in_app_flash_program_ctrl #(.PROG_CYC(PC), .ERASE_CYC(EC), .MAKER_CODE(MAKER),
    .PART_CODE(PART)) in_app_flash_program_ctrl_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .sfr_req_i(sfr_req), .sfr_rdata_o(sfr_rdata), .brownout_low_i(bo_low),
    .brownout_inhibit_i(bo_inh), .brownout_detect_enable_i(bo_det),
    .brownout_reset_enable_i(bo_rst), .unique_code_i(uid), .cpu_hold_o(cpu_hold),
    .internal_rc_osc_en_o(osc_en), .flash_req_o(freq), .flash_rdata_i(frdata));
  flash_array_model flash_array_model_i (.clk_i(sys_clk), .req_i(freq), .rdata_o(frdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_req = '{1'b1, a, d};
    @(negedge sys_clk);
    sfr_req.wr = 1'b0;
  endtask : wr

  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
    wr(a, d);
  endtask : pwr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr_req.addr = a;
    @(negedge sys_clk);
    `CHK(sfr_rdata, e)
  endtask : rchk

  // Loads everything before the trigger, then counts the cycles the CPU is held
  task automatic op(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                    input int n_exp, input logic [7:0] cc_exp);
    int n;
    n = 0;
    wr(8'hAF, cmd);
    wr(8'hA7, a[15:8]);
    wr(8'hA6, a[7:0]);
    wr(8'hAE, d);
    // No interrupt source is modelled, so the trigger always runs with interrupts off
    pwr(8'hA4, 8'h01);
    while (cpu_hold === 1'b1 && n < 64) begin
      seen = freq;
      n++;
      @(negedge sys_clk);
    end
    `CHK(n, n_exp)
    rchk(8'h9F, cc_exp);
  endtask : op

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] ra [8] = '{8'h9F, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAE, 8'hAF, 8'hB0};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00};
    for (int i = 0; i < 8; i++) rchk(ra[i], rv[i]);
  endtask : t_reset

  task automatic t_unlock();
    wr(8'h9F, 8'h01);
    rchk(8'h9F, 8'h00);
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
    wr(8'hA6, 8'h00);
    wr(8'h9F, 8'h01);
    rchk(8'h9F, 8'h00);
    pwr(8'h9F, 8'h01);
    `CHK(osc_en, 1'b1)
    pwr(8'hA5, 8'h03);
    rchk(8'hA5, 8'h03);
  endtask : t_unlock

  task automatic t_prog_erase();
    op(8'h21, 16'h0201, 8'h5A, PC, 8'h01);
    `CHK(seen.addr, 16'h0201)
    `CHK(seen.wdata, 8'h5A)
    rchk(8'hA4, 8'h00);
    op(8'h00, 16'h0201, 8'h00, 1, 8'h01);
    rchk(8'hAE, 8'h5A);
    // The bench runs no code from flash, so no erased page is ever in use
    op(8'h22, 16'h0280, 8'hFF, EC, 8'h01);
    `CHK(seen.addr, 16'h0200)
    op(8'h00, 16'h0201, 8'h00, 1, 8'h01);
    rchk(8'hAE, 8'hFF);
  endtask : t_prog_erase

  task automatic t_regions();
    op(8'h61, 16'h0010, 8'h3C, PC, 8'h01);
    op(8'h40, 16'h0010, 8'h00, 1, 8'h01);
    rchk(8'hAE, 8'h3C);
    op(8'h00, 16'h0010, 8'h00, 1, 8'h01);
    rchk(8'hAE, 8'hFF);
  endtask : t_regions

  task automatic t_faults();
    logic [7:0]  fc [7] = '{8'h21, 8'h41, 8'h05, 8'hE1, 8'h80, 8'hC0, 8'hE2};
    logic [15:0] fa [7] = '{16'h4000, 16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h0003,
                            16'h0000};
    for (int i = 0; i < 7; i++) begin
      op(fc[i], fa[i], 8'h00, 0, 8'h41);
      op(8'h00, 16'h0000, 8'h00, 1, 8'h41);
      pwr(8'h9F, 8'h01);
      rchk(8'h9F, 8'h01);
    end
  endtask : t_faults

  task automatic t_config();
    pwr(8'hA5, 8'h07);
    op(8'hE1, 16'h0004, 8'hA5, PC, 8'h01);
    op(8'hC0, 16'h0004, 8'h00, 1, 8'h01);
    rchk(8'hAE, 8'hA5);
    op(8'hE2, 16'h0000, 8'hFF, EC, 8'h01);
    op(8'hC0, 16'h0004, 8'h00, 1, 8'h01);
    rchk(8'hAE, 8'hFF);
  endtask : t_config

  task automatic t_ident();
    op(8'h0B, 16'h0777, 8'h00, 0, 8'h01);
    rchk(8'hAE, MAKER);
    op(8'h0C, 16'h0000, 8'h00, 0, 8'h01);
    rchk(8'hAE, PART[7:0]);
    op(8'h0C, 16'h0001, 8'h00, 0, 8'h01);
    rchk(8'hAE, PART[15:8]);
    for (int i = 0; i < 12; i++) begin
      op(8'hC4, 16'(i), 8'h00, 0, 8'h01);
      rchk(8'hAE, uid[8*i +: 8]);
    end
  endtask : t_ident

  // Each of the three qualifiers alone must lift the brown-out block
  task automatic t_brownout();
    bo_low = 1'b1;
    repeat (4) @(negedge sys_clk);
    op(8'h21, 16'h0300, 8'h00, 0, 8'h41);
    pwr(8'h9F, 8'h01);
    bo_rst = 1'b1;
    op(8'h21, 16'h0301, 8'h00, PC, 8'h01);
    bo_rst = 1'b0;
    bo_inh = 1'b0;
    op(8'h21, 16'h0302, 8'h00, PC, 8'h01);
    bo_inh = 1'b1;
    bo_det = 1'b0;
    op(8'h21, 16'h0303, 8'h00, PC, 8'h01);
    bo_det = 1'b1;
    bo_low = 1'b0;
    repeat (4) @(negedge sys_clk);
    op(8'h21, 16'h0300, 8'h00, PC, 8'h01);
  endtask : t_brownout

  task automatic t_disable();
    pwr(8'h9F, 8'h00);
    `CHK(osc_en, 1'b0)
    op(8'h00, 16'h0300, 8'h77, 0, 8'h00);
    rchk(8'hAE, 8'h77);
  endtask : t_disable

  initial begin
    sfr_req = '0;
    bo_low = 1'b0;
    bo_inh = 1'b1;
    bo_det = 1'b1;
    bo_rst = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    t_reset();
    t_unlock();
    t_prog_erase();
    t_regions();
    t_faults();
    t_config();
    t_ident();
    t_brownout();
    t_disable();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
